// ==== verilog/cuc_defs.svh ====
// register offsets, field positions, reset values and command codes
// assumes 6-bit register addresses and 10-bit nonvolatile word addresses
`ifndef CUC_DEFS_SVH
`define CUC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CUC_ADDR_TEMP_RATIO 6'h29
`define CUC_ADDR_ALARM_CFG 6'h2A
`define CUC_ADDR_RUN 6'h2F
`define CUC_ADDR_LOCK 6'h30
`define CUC_ADDR_TAG_LO 6'h31
`define CUC_ADDR_TAG_HI 6'h32
`define CUC_ADDR_CMD 6'h36
`define CUC_ADDR_TRIM_LO 6'h3E
`define CUC_ADDR_TRIM_HI 6'h3F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CUC_ALARM_B_BIT 6
`define CUC_ALARM_A_BIT 4
`define CUC_HANDSHAKE_BIT 3
`define CUC_SPEED_BIT 2
`define CUC_MED_R_BIT 1
`define CUC_MED_C_BIT 0
`define CUC_RUN_BIT 0
`define CUC_LOCK_W 4

// ----------------------------------------------------------------
// reset values and command codes
// ----------------------------------------------------------------
`define CUC_RST_BYTE 8'h00
`define CUC_CMD_STORE 8'h2D
`define CUC_CMD_RECALL 8'h59
`define CUC_CMD_ERASE 8'hB8

// ----------------------------------------------------------------
// nonvolatile lock range limits (word addresses)
// ----------------------------------------------------------------
`define CUC_LOCK0_END 10'h2BF
`define CUC_LOCK1_END 10'h33F
`define CUC_LOCK2_END 10'h3BF
`define CUC_LOCK3_END 10'h3EF
`define CUC_LOCK3_TOP 10'h3FE

`endif

// ==== verilog/cuc_pkg.sv ====
// types shared by the upper configuration block
// assumes the address widths of cuc_defs.svh
package cuc_pkg;

    // ----------------------------------------------------------------
    // serial port register access, one access per strobe
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cuc_reg_req_t;

    // ----------------------------------------------------------------
    // nonvolatile access check request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic [9:0] addr;
    } cuc_nvm_acc_t;

    // ----------------------------------------------------------------
    // enabled nonvolatile operation
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        cuc_op_none,
        cuc_op_store,
        cuc_op_recall,
        cuc_op_erase
    } cuc_nvm_op_t;

endpackage : cuc_pkg

// ==== verilog/cuc_result_hold.sv ====
// one result word holder with optional read handshake
// assumes loads and reads are one-cycle pulses on i_clk
module cuc_result_hold #(
    parameter int W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_data,
    input wire logic i_read,
    input wire logic i_handshake,
    output logic [W-1:0] o_word,
    output logic o_unread
);

    // ----------------------------------------------------------------
    // acceptance and unread flag
    // ----------------------------------------------------------------
    // with handshake on, a held unread value blocks new loads
    wire accept = i_load && (!i_handshake || !o_unread);
    // a new value wins over a read in the same cycle
    wire next_unread = accept ? 1'h1 : (i_read ? 1'h0 : o_unread);

    // word and flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word <= '0;
            o_unread <= 1'h0;
        end else begin
            if (accept) begin
                o_word <= i_data;
            end
            o_unread <= next_unread;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_hold_unread;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_handshake && o_unread && i_load) |=> $stable(o_word);
    endproperty
    a_hold_unread: assert property (p_hold_unread) else $error("unread result overwritten");

endmodule : cuc_result_hold

// ==== verilog/cuc_cfg_regs.sv ====
// upper configuration registers, run switch and nonvolatile control
// assumes one register access per strobe from the serial port logic
`include "cuc_defs.svh"

module cuc_cfg_regs
    import cuc_pkg::*;
#(
    parameter int RES_W = 32,
    parameter int RES_N = 8,
    parameter logic [7:0] TRIM_LO_INIT = 8'h00,
    parameter logic [7:0] TRIM_HI_INIT = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire cuc_reg_req_t i_reg,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_fw_linearize,
    input wire logic i_alarm_z,
    input wire logic i_alarm_theta,
    output logic o_alarm_pin_a,
    output logic o_alarm_pin_b,
    output logic [7:0] o_temp_ratio_sel,
    output logic o_median_r_en,
    output logic o_median_c_en,
    output logic o_run,
    input wire logic [RES_N-1:0] i_res_load,
    input wire logic [RES_W-1:0] i_res_data,
    input wire logic [RES_N-1:0] i_res_read,
    output logic [RES_N*RES_W-1:0] o_res_words,
    output logic [RES_N-1:0] o_res_unread,
    input wire cuc_nvm_acc_t i_nvm,
    output logic o_nvm_grant,
    output logic o_nvm_blocked,
    output cuc_nvm_op_t o_nvm_op,
    input wire logic i_erase_done
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] alarm_cfg;
    logic [`CUC_LOCK_W-1:0] lock;
    logic [7:0] tag_lo;
    logic [7:0] tag_hi;
    logic [7:0] cmd;
    logic [7:0] trim_lo;
    logic [7:0] trim_hi;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire access = i_reg.wr || i_reg.rd;
    wire wr_temp = i_reg.wr && (i_reg.addr == `CUC_ADDR_TEMP_RATIO);
    wire wr_alarm = i_reg.wr && (i_reg.addr == `CUC_ADDR_ALARM_CFG);
    wire wr_run = i_reg.wr && (i_reg.addr == `CUC_ADDR_RUN);
    wire wr_lock = i_reg.wr && (i_reg.addr == `CUC_ADDR_LOCK);
    wire wr_tag_lo = i_reg.wr && (i_reg.addr == `CUC_ADDR_TAG_LO);
    wire wr_tag_hi = i_reg.wr && (i_reg.addr == `CUC_ADDR_TAG_HI);
    wire wr_cmd = i_reg.wr && (i_reg.addr == `CUC_ADDR_CMD);
    wire wr_trim_lo = i_reg.wr && (i_reg.addr == `CUC_ADDR_TRIM_LO);
    wire wr_trim_hi = i_reg.wr && (i_reg.addr == `CUC_ADDR_TRIM_HI);

    // ----------------------------------------------------------------
    // serial tag bytes
    // ----------------------------------------------------------------
    // writable only while zero, cleared by a finished erase
    wire tag_lo_ok = wr_tag_lo && (tag_lo == `CUC_RST_BYTE);
    wire tag_hi_ok = wr_tag_hi && (tag_hi == `CUC_RST_BYTE);
    wire [7:0] next_tag_lo = tag_lo_ok ? i_reg.wdata : (i_erase_done ? `CUC_RST_BYTE : tag_lo);
    wire [7:0] next_tag_hi = tag_hi_ok ? i_reg.wdata : (i_erase_done ? `CUC_RST_BYTE : tag_hi);

    // ----------------------------------------------------------------
    // memory command
    // ----------------------------------------------------------------
    // a new write takes the code; any other access clears it
    wire [7:0] next_cmd = wr_cmd ? i_reg.wdata : (access ? `CUC_RST_BYTE : cmd);
    // only the three known codes map to an operation
    wire cuc_nvm_op_t next_op = (next_cmd == `CUC_CMD_STORE) ? cuc_op_store :
        (next_cmd == `CUC_CMD_RECALL) ? cuc_op_recall :
        (next_cmd == `CUC_CMD_ERASE) ? cuc_op_erase : cuc_op_none;

    // ----------------------------------------------------------------
    // nonvolatile range lock
    // ----------------------------------------------------------------
    wire [9:0] na = i_nvm.addr;
    wire in_r0 = (na <= `CUC_LOCK0_END);
    wire in_r1 = (na > `CUC_LOCK0_END) && (na <= `CUC_LOCK1_END);
    wire in_r2 = (na > `CUC_LOCK1_END) && (na <= `CUC_LOCK2_END);
    wire in_r3 = ((na > `CUC_LOCK2_END) && (na <= `CUC_LOCK3_END)) || (na >= `CUC_LOCK3_TOP);
    wire lock_hit = (lock[0] && in_r0) || (lock[1] && in_r1) || (lock[2] && in_r2) || (lock[3] && in_r3);

    // ----------------------------------------------------------------
    // alarm sources and filter enables
    // ----------------------------------------------------------------
    // select 0 picks Z, 1 picks Theta; linearising firmware only
    wire next_alarm_a = i_fw_linearize && (alarm_cfg[`CUC_ALARM_A_BIT] ? i_alarm_theta : i_alarm_z);
    wire next_alarm_b = i_fw_linearize && (alarm_cfg[`CUC_ALARM_B_BIT] ? i_alarm_theta : i_alarm_z);
    wire next_med_r = i_fw_linearize && alarm_cfg[`CUC_MED_R_BIT];
    wire next_med_c = i_fw_linearize && alarm_cfg[`CUC_MED_C_BIT];

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] rd_mux = (i_reg.addr == `CUC_ADDR_TEMP_RATIO) ? o_temp_ratio_sel :
        (i_reg.addr == `CUC_ADDR_ALARM_CFG) ? alarm_cfg :
        (i_reg.addr == `CUC_ADDR_RUN) ? {7'h00, o_run} :
        (i_reg.addr == `CUC_ADDR_LOCK) ? {4'h0, lock} :
        (i_reg.addr == `CUC_ADDR_TAG_LO) ? tag_lo :
        (i_reg.addr == `CUC_ADDR_TAG_HI) ? tag_hi :
        (i_reg.addr == `CUC_ADDR_CMD) ? cmd :
        (i_reg.addr == `CUC_ADDR_TRIM_LO) ? trim_lo :
        (i_reg.addr == `CUC_ADDR_TRIM_HI) ? trim_hi : 8'h00;

    // ----------------------------------------------------------------
    // software-written registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_temp_ratio_sel <= `CUC_RST_BYTE;
            alarm_cfg <= `CUC_RST_BYTE;
            o_run <= 1'h0;
            lock <= '0;
            trim_lo <= TRIM_LO_INIT;
            trim_hi <= TRIM_HI_INIT;
        end else begin
            if (wr_temp) o_temp_ratio_sel <= i_reg.wdata;
            if (wr_alarm) alarm_cfg <= i_reg.wdata;
            if (wr_run) o_run <= i_reg.wdata[`CUC_RUN_BIT];
            if (wr_lock) lock <= i_reg.wdata[`CUC_LOCK_W-1:0];
            if (wr_trim_lo) trim_lo <= i_reg.wdata;
            if (wr_trim_hi) trim_hi <= i_reg.wdata;
        end
    end

    // tag, command and operation state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tag_lo <= `CUC_RST_BYTE;
            tag_hi <= `CUC_RST_BYTE;
            cmd <= `CUC_RST_BYTE;
            o_nvm_op <= cuc_op_none;
        end else begin
            tag_lo <= next_tag_lo;
            tag_hi <= next_tag_hi;
            cmd <= next_cmd;
            o_nvm_op <= next_op;
        end
    end

    // registered outputs: read data, lock verdict, alarms, filters
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'h0;
            o_nvm_grant <= 1'h0;
            o_nvm_blocked <= 1'h0;
            o_alarm_pin_a <= 1'h0;
            o_alarm_pin_b <= 1'h0;
            o_median_r_en <= 1'h0;
            o_median_c_en <= 1'h0;
        end else begin
            o_rdata <= i_reg.rd ? rd_mux : 8'h00;
            o_rvalid <= i_reg.rd;
            o_nvm_grant <= i_nvm.req && !lock_hit;
            o_nvm_blocked <= i_nvm.req && lock_hit;
            o_alarm_pin_a <= next_alarm_a;
            o_alarm_pin_b <= next_alarm_b;
            o_median_r_en <= next_med_r;
            o_median_c_en <= next_med_c;
        end
    end

    // ----------------------------------------------------------------
    // result holders
    // ----------------------------------------------------------------
    // while idle (run bit off), no result is updated
    genvar k;
    generate
        for (k = 0; k < RES_N; k++) begin : g_res
            cuc_result_hold #(.W(RES_W)) u_hold (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_load(i_res_load[k] && o_run),
                .i_data(i_res_data),
                .i_read(i_res_read[k]),
                .i_handshake(alarm_cfg[`CUC_HANDSHAKE_BIT]),
                .o_word(o_res_words[k*RES_W +: RES_W]),
                .o_unread(o_res_unread[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_temp_sel;
        wr_temp |=> (o_temp_ratio_sel == $past(i_reg.wdata));
    endproperty
    a_temp_sel: assert property (p_temp_sel) else $error("ratio selector not taken");

    property p_alarm_z;
        (i_fw_linearize && !alarm_cfg[`CUC_ALARM_A_BIT] && i_alarm_z && !wr_alarm) |=> o_alarm_pin_a;
    endproperty
    a_alarm_z: assert property (p_alarm_z) else $error("alarm a missed Z source");

    property p_median_off;
        !i_fw_linearize |=> (!o_median_r_en && !o_median_c_en);
    endproperty
    a_median_off: assert property (p_median_off) else $error("median filter on without firmware");

    property p_idle_hold;
        (!o_run && !wr_run) ##1 !o_run |-> $stable(o_res_words);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("result changed while idle");

    property p_lock0;
        (i_nvm.req && lock[0] && (i_nvm.addr <= `CUC_LOCK0_END)) |=> (o_nvm_blocked && !o_nvm_grant);
    endproperty
    a_lock0: assert property (p_lock0) else $error("locked range not blocked");

    property p_tag_fixed;
        (wr_tag_lo && (tag_lo != 8'h00) && !i_erase_done) |=> $stable(tag_lo);
    endproperty
    a_tag_fixed: assert property (p_tag_fixed) else $error("nonzero tag overwritten");

    property p_store;
        (wr_cmd && (i_reg.wdata == `CUC_CMD_STORE)) |=> (o_nvm_op == cuc_op_store);
    endproperty
    a_store: assert property (p_store) else $error("store code not decoded");

    property p_auto_clear;
        (o_nvm_op != cuc_op_none) && access && !wr_cmd |=> (o_nvm_op == cuc_op_none) && (cmd == 8'h00);
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("command not cleared by access");

    property p_bad_code;
        (wr_cmd && (i_reg.wdata != `CUC_CMD_STORE) && (i_reg.wdata != `CUC_CMD_RECALL)
            && (i_reg.wdata != `CUC_CMD_ERASE)) |=> (o_nvm_op == cuc_op_none);
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("unknown code started operation");

endmodule : cuc_cfg_regs

// ==== bench/cuc_host_model.sv ====
// host model: register accesses from the serial port side
// assumes the block takes a strobe at a rising edge and answers a read one cycle later
`include "cuc_defs.svh"

module cuc_host_model
    import cuc_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output cuc_reg_req_t o_reg
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle lines until the first access
    initial o_reg = '{wr: 1'b0, rd: 1'b0, addr: 6'h00, wdata: 8'h00};

    // one strobe held to its edge, answer taken, strobe dropped with address and data inverted
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [8:0] r);
        @(posedge i_clk);
        #1;
        o_reg = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clk);
        #1;
        r = {i_rvalid, i_rdata};
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer

    // write with the values a host must keep
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [8:0] r;
        logic [7:0] v;
        v = d;
        if (a == `CUC_ADDR_ALARM_CFG) v[`CUC_SPEED_BIT] = 1'b0;
        if ((a >= 6'h33 && a <= 6'h35) || (a >= 6'h37 && a <= 6'h3D)) v = 8'h00;
        if (a != `CUC_ADDR_TRIM_LO && a != `CUC_ADDR_TRIM_HI) xfer(1'b1, a, v, r);
    endtask : wr

    // run bit off around a configuration change
    task automatic cfg(input logic [5:0] a, input logic [7:0] d);
        wr(`CUC_ADDR_RUN, 8'h00);
        wr(a, d);
        wr(`CUC_ADDR_RUN, 8'h01);
    endtask : cfg

    task automatic rd(input logic [5:0] a, output logic [8:0] r);
        xfer(1'b0, a, 8'h00, r);
    endtask : rd
endmodule : cuc_host_model

// ==== bench/tb_top.sv ====
// self-checking bench for the upper configuration block
// assumes cuc_host_model drives the register port
module tb_top
    import cuc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] TRIM_LO = 8'h5A;
    localparam logic [7:0] TRIM_HI = 8'hC3;
    logic clk, rst_n, rvalid, fw_lin, az, ath, pa, pb, mr, mc, run, grant, blocked, erase_done;
    logic [7:0] rdata, sel, res_load, res_read, res_unread;
    logic [31:0] res_data;
    logic [255:0] res_words;
    cuc_reg_req_t reg_req;
    cuc_nvm_acc_t nvm;
    cuc_nvm_op_t op;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    cuc_cfg_regs #(.TRIM_LO_INIT(TRIM_LO), .TRIM_HI_INIT(TRIM_HI)) DUT (
        .i_clk(clk), .i_rst_n(rst_n), .i_reg(reg_req), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_fw_linearize(fw_lin), .i_alarm_z(az), .i_alarm_theta(ath), .o_alarm_pin_a(pa),
        .o_alarm_pin_b(pb), .o_temp_ratio_sel(sel), .o_median_r_en(mr), .o_median_c_en(mc),
        .o_run(run), .i_res_load(res_load), .i_res_data(res_data), .i_res_read(res_read),
        .o_res_words(res_words), .o_res_unread(res_unread), .i_nvm(nvm), .o_nvm_grant(grant),
        .o_nvm_blocked(blocked), .o_nvm_op(op), .i_erase_done(erase_done));
    cuc_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_reg(reg_req));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // one result load and read pulse pair
    task automatic pulse(input logic [7:0] ld, input logic [7:0] rm, input logic [31:0] d);
        step();
        res_load = ld;
        res_read = rm;
        res_data = d;
        step();
        res_load = 8'h00;
        res_read = 8'h00;
        res_data = ~d;
    endtask : pulse

    function automatic logic exp_blk(input logic [3:0] l, input int a);
        return (l[0] && a <= 703) || (l[1] && a >= 704 && a <= 831) || (l[2] && a >= 832 && a <= 959)
            || (l[3] && ((a >= 960 && a <= 1007) || a >= 1022));
    endfunction : exp_blk

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [8:0] r;
        logic [5:0] a [10] = '{6'h29, 6'h2A, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h36, 6'h3E, 6'h3F, 6'h33};
        chk({run, op}, 3'b000);
        foreach (a[i]) begin
            host.rd(a[i], r);
            chk(r, {1'b1, (a[i] == 6'h3E) ? TRIM_LO : (a[i] == 6'h3F) ? TRIM_HI : 8'h00});
        end
        $display("t_reset done");
    endtask : t_reset

    task automatic t_cfg();
        logic [8:0] r;
        host.cfg(6'h29, 8'hA5);
        host.rd(6'h29, r);
        chk({r, sel}, 17'h1A5A5);
        host.cfg(6'h2A, 8'h17);
        host.rd(6'h2A, r);
        chk(r, 9'h113);
        fw_lin = 1'b1;
        ath = 1'b1;
        step();
        step();
        chk({pa, pb, mr, mc}, 4'b1011);
        az = 1'b1;
        ath = 1'b0;
        step();
        step();
        chk({pa, pb}, 2'b01);
        // alarm a back on Z, alarm b on Theta, filters kept on
        host.cfg(6'h2A, 8'h43);
        chk({pa, pb, mr, mc}, 4'b1011);
        fw_lin = 1'b0;
        step();
        step();
        chk({pa, pb, mr, mc}, 4'b0000);
        host.wr(6'h2F, 8'hFE);
        chk(run, 1'b0);
        host.wr(6'h2F, 8'hFF);
        host.rd(6'h2F, r);
        chk({r, run}, 10'h203);
        $display("t_cfg done");
    endtask : t_cfg

    task automatic t_lock();
        logic [8:0] r;
        logic [3:0] l [2] = '{4'h5, 4'hA};
        int a [12] = '{0, 703, 704, 831, 832, 959, 960, 1007, 1008, 1021, 1022, 1023};
        foreach (l[j]) begin
            host.cfg(6'h30, {4'hF, l[j]});
            host.rd(6'h30, r);
            chk(r, {5'h10, l[j]});
            foreach (a[i]) begin
                step();
                nvm = '{req: 1'b1, addr: 10'(a[i])};
                step();
                nvm = '{req: 1'b0, addr: ~10'(a[i])};
                chk({grant, blocked}, {!exp_blk(l[j], a[i]), exp_blk(l[j], a[i])});
            end
        end
        $display("t_lock done");
    endtask : t_lock

    task automatic t_tags();
        logic [8:0] r;
        for (int a = 'h31; a <= 'h32; a++) begin
            host.wr(6'(a), 8'h12);
            host.wr(6'(a), 8'h34);
            host.rd(6'(a), r);
            chk(r, 9'h112);
        end
        step();
        erase_done = 1'b1;
        step();
        erase_done = 1'b0;
        host.rd(6'h32, r);
        chk(r, 9'h100);
        host.wr(6'h31, 8'h56);
        host.rd(6'h31, r);
        chk(r, 9'h156);
        $display("t_tags done");
    endtask : t_tags

    task automatic t_cmd();
        logic [8:0] r;
        logic [7:0] c [4] = '{8'h2D, 8'h59, 8'hB8, 8'h77};
        cuc_nvm_op_t e [4] = '{cuc_op_store, cuc_op_recall, cuc_op_erase, cuc_op_none};
        foreach (c[i]) begin
            host.wr(6'h36, c[i]);
            step();
            step();
            chk(op, e[i]);
            host.rd(6'h29, r);
            chk(op, cuc_op_none);
            host.rd(6'h36, r);
            chk(r, 9'h100);
        end
        $display("t_cmd done");
    endtask : t_cmd

    task automatic t_results();
        host.wr(6'h2F, 8'h00);
        pulse(8'h04, 8'h00, 32'h1111_1111);
        chk(res_words[95:64], 32'h0000_0000);
        chk(res_unread[2], 1'b0);
        host.cfg(6'h2A, 8'h08);
        pulse(8'h04, 8'h00, 32'hAAAA_0001);
        pulse(8'h04, 8'h00, 32'hBBBB_0002);
        chk(res_words[95:64], 32'hAAAA_0001);
        chk(res_unread[2], 1'b1);
        pulse(8'h00, 8'h04, 32'h0);
        chk(res_unread[2], 1'b0);
        pulse(8'h04, 8'h00, 32'hBBBB_0002);
        chk(res_words[95:64], 32'hBBBB_0002);
        host.cfg(6'h2A, 8'h00);
        pulse(8'h04, 8'h00, 32'hCCCC_0003);
        chk(res_words[95:64], 32'hCCCC_0003);
        $display("t_results done");
    endtask : t_results

    // reset in mid-run clears the ratio selector, run bit and result flags
    task automatic t_rerun();
        logic [8:0] r;
        host.cfg(6'h29, 8'h3C);
        rst_n = 1'b0;
        step();
        chk(sel, 8'h00);
        chk({run, res_unread}, 9'h000);
        rst_n = 1'b1;
        host.rd(6'h29, r);
        chk(r, 9'h100);
        $display("t_rerun done");
    endtask : t_rerun

    // ----------------------------------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        fw_lin = 1'b0;
        az = 1'b0;
        ath = 1'b0;
        res_load = 8'h00;
        res_read = 8'h00;
        res_data = 32'h0000_0000;
        nvm = '{req: 1'b0, addr: 10'h000};
        erase_done = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_cfg();
        t_lock();
        t_tags();
        t_cmd();
        t_results();
        t_rerun();
        tally_and_finish();
    end
endmodule : tb_top
